// *** tmr_pkg.sv ***
// constants and register map of the capture/auto-reload timer
// Behaviour
// (RULE_01) capture enable picks capture or auto-reload
// (RULE_02) source select: 0 start-of-frame, 1 oscillator fall
// (RULE_03) unsplit capture: 16-bit count wraps to zero
// (RULE_04) capture copies count bytes into reload bytes
// (RULE_05) split capture: two free 8-bit counters wrap
// (RULE_06) high byte wrap sets high overflow flag
// (RULE_07) high flag requests interrupt; software clears it
// (RULE_08) low byte wrap sets low flag always
// (RULE_09) low flag interrupts only with its enable
// (RULE_10) split enable: one 16-bit or two 8-bit
// (RULE_11) run gates counting; split gates high only
// (RULE_12) external select: divide-by-12 or external divide-by-8
// (RULE_13) external clock synchronized before counting
// (RULE_14) low reload: reload byte or captured low
// (RULE_15) high reload: reload byte or captured high
// (RULE_16) count bytes form 16-bit or two 8-bit
// (RULE_17) 16-bit wrap loads reload, sets high flag
// (RULE_18) split wraps reload each byte separately
// (RULE_19) per-byte select: system clock or external choice
// (RULE_20) each capture edge gives one strobe, one latch
package tmr_pkg;

  // register addresses on the special-function bus
  localparam logic [7:0] TMR_ADDR_CONTROL     = 8'hC8;
  localparam logic [7:0] TMR_ADDR_RELOAD_LOW  = 8'hCA;
  localparam logic [7:0] TMR_ADDR_RELOAD_HIGH = 8'hCB;
  localparam logic [7:0] TMR_ADDR_COUNT_LOW   = 8'hCC;
  localparam logic [7:0] TMR_ADDR_COUNT_HIGH  = 8'hCD;

  // control register bit positions
  localparam int TMR_BIT_HIGH_OVF   = 7;
  localparam int TMR_BIT_LOW_OVF    = 6;
  localparam int TMR_BIT_LOW_IRQ_EN = 5;
  localparam int TMR_BIT_CAPTURE_EN = 4;
  localparam int TMR_BIT_SPLIT_EN   = 3;
  localparam int TMR_BIT_RUN        = 2;
  localparam int TMR_BIT_CAP_SRC    = 1;
  localparam int TMR_BIT_EXT_CLK    = 0;

  // value after reset and byte maximum
  localparam logic [7:0] TMR_RESET_BYTE = 8'h00;
  localparam logic [7:0] TMR_BYTE_MAX   = 8'hFF;

  // prescaler counts
  localparam logic [3:0] TMR_DIV_SYS_LAST = 4'hB;
  localparam logic [2:0] TMR_DIV_EXT_LAST = 3'h7;

endpackage : tmr_pkg

// *** tmr_timer.sv ***
// capture/auto-reload timer with special-function register access
`timescale 1ns/1ps
module tmr_timer
  import tmr_pkg::*;
(
  // clock, reset, enable
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic       clk_en,
  // special-function register bus
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_rd,
  output logic      [7:0] sfr_rdata,
  // per-byte clock selects from the clock control register
  input  wire logic       high_byte_clock_select,
  input  wire logic       low_byte_clock_select,
  // asynchronous sources
  input  wire logic       ext_clock,
  input  wire logic       usb_sof,
  input  wire logic       low_frequency_oscillator,
  // interrupt side
  input  wire logic       timer_irq_global_enable,
  output logic            timer_irq_req,
  output logic            capture_strobe
);

  // control register fields
  logic       high_overflow_flag;
  logic       low_overflow_flag;
  logic       low_byte_irq_enable;
  logic       capture_enable;
  logic       split_enable;
  logic       run_control;
  logic       capture_source_select;
  logic       ext_clock_select;

  // data registers
  logic [7:0] reload_low_reg;
  logic [7:0] reload_high_reg;
  logic [7:0] count_low_reg;
  logic [7:0] count_high_reg;

  // synchronisers and edge history
  logic [1:0] ext_sync_reg;
  logic       ext_prev_reg;
  logic [1:0] sof_sync_reg;
  logic       sof_prev_reg;
  logic [1:0] lfo_sync_reg;
  logic       lfo_prev_reg;

  // prescalers
  logic [3:0] div_sys_reg;
  logic [2:0] div_ext_reg;
  logic       sys_tick;
  logic       ext_tick;

  // derived strobes
  logic       sof_event;
  logic       lfo_event;
  logic       capture_event;
  logic       src_tick;
  logic       tick_low;
  logic       tick_high;
  logic       inc_low;
  logic       inc_high;
  logic       wrap_low;
  logic       wrap_high;

  // register write strobes
  logic       wr_control;
  logic       wr_reload_low;
  logic       wr_reload_high;
  logic       wr_count_low;
  logic       wr_count_high;

  // address decode for writes
  assign wr_control     = sfr_wr && (sfr_addr == TMR_ADDR_CONTROL);
  assign wr_reload_low  = sfr_wr && (sfr_addr == TMR_ADDR_RELOAD_LOW);
  assign wr_reload_high = sfr_wr && (sfr_addr == TMR_ADDR_RELOAD_HIGH);
  assign wr_count_low   = sfr_wr && (sfr_addr == TMR_ADDR_COUNT_LOW);
  assign wr_count_high  = sfr_wr && (sfr_addr == TMR_ADDR_COUNT_HIGH);

  // two-flop synchronisers; the first stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ext_sync_reg <= 2'h0;
      sof_sync_reg <= 2'h0;
      lfo_sync_reg <= 2'h0;
    end else if (clk_en) begin
      ext_sync_reg <= {ext_sync_reg[0], ext_clock}; // see RULE_13
      sof_sync_reg <= {sof_sync_reg[0], usb_sof}; // see RULE_20
      lfo_sync_reg <= {lfo_sync_reg[0], low_frequency_oscillator}; // see RULE_20
    end
  end

  // edge history taken from the second stage only
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ext_prev_reg <= 1'b0;
      sof_prev_reg <= 1'b0;
      lfo_prev_reg <= 1'b0;
    end else if (clk_en) begin
      ext_prev_reg <= ext_sync_reg[1];
      sof_prev_reg <= sof_sync_reg[1];
      lfo_prev_reg <= lfo_sync_reg[1];
    end
  end

  // start-of-frame rises, oscillator falls; one cycle per edge
  assign sof_event = sof_sync_reg[1] && !sof_prev_reg; // see RULE_20
  assign lfo_event = !lfo_sync_reg[1] && lfo_prev_reg; // see RULE_20

  // source picked by select bit, only while capture is on
  assign capture_event = capture_enable &&
                         (capture_source_select ? lfo_event : sof_event); // see RULE_01, RULE_02

  // system clock divided by 12, free running
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      div_sys_reg <= 4'h0;
    end else if (clk_en) begin
      if (div_sys_reg == TMR_DIV_SYS_LAST) begin
        div_sys_reg <= 4'h0;
      end else begin
        div_sys_reg <= div_sys_reg + 4'h1;
      end
    end
  end

  assign sys_tick = (div_sys_reg == TMR_DIV_SYS_LAST); // see RULE_12

  // external clock divided by 8, counted on synchronised rising edges
  // external clock must stay below a quarter of the system clock
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      div_ext_reg <= 3'h0;
    end else if (clk_en && ext_sync_reg[1] && !ext_prev_reg) begin
      div_ext_reg <= div_ext_reg + 3'h1; // see RULE_13
    end
  end

  assign ext_tick = ext_sync_reg[1] && !ext_prev_reg &&
                    (div_ext_reg == TMR_DIV_EXT_LAST); // see RULE_12, RULE_13

  // shared non-system choice, then per-byte system clock override
  assign src_tick  = ext_clock_select ? ext_tick : sys_tick; // see RULE_12
  assign tick_low  = low_byte_clock_select ? 1'b1 : src_tick; // see RULE_19
  assign tick_high = high_byte_clock_select ? 1'b1 : src_tick; // see RULE_19

  // run gates both halves in 16-bit mode, high byte only when split
  assign inc_low  = split_enable ? tick_low : (run_control && tick_low); // see RULE_11
  assign inc_high = split_enable ? (run_control && tick_high)
                                 : (inc_low && (count_low_reg == TMR_BYTE_MAX)); // see RULE_10, RULE_16

  // byte wraps from FF to 00
  assign wrap_low  = inc_low && (count_low_reg == TMR_BYTE_MAX); // see RULE_08
  assign wrap_high = inc_high && (count_high_reg == TMR_BYTE_MAX); // see RULE_06

  // low byte counter; software write overrides the hardware step
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      count_low_reg <= TMR_RESET_BYTE;
    end else if (clk_en) begin
      if (wr_count_low) begin
        count_low_reg <= sfr_wdata;
      end else if (wrap_low && !capture_enable && split_enable) begin
        count_low_reg <= reload_low_reg; // see RULE_18
      end else if (wrap_low && !capture_enable && wrap_high) begin
        count_low_reg <= reload_low_reg; // see RULE_17
      end else if (inc_low) begin
        count_low_reg <= count_low_reg + 8'h01; // see RULE_03, RULE_05, RULE_16
      end
    end
  end

  // high byte counter; reload only in auto-reload modes
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      count_high_reg <= TMR_RESET_BYTE;
    end else if (clk_en) begin
      if (wr_count_high) begin
        count_high_reg <= sfr_wdata;
      end else if (wrap_high && !capture_enable) begin
        count_high_reg <= reload_high_reg; // see RULE_17, RULE_18
      end else if (inc_high) begin
        count_high_reg <= count_high_reg + 8'h01; // see RULE_03, RULE_05, RULE_16
      end
    end
  end

  // reload registers; a capture beats a software write in the same cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reload_low_reg  <= TMR_RESET_BYTE;
      reload_high_reg <= TMR_RESET_BYTE;
    end else if (clk_en) begin
      if (capture_event) begin
        reload_low_reg  <= count_low_reg; // see RULE_04, RULE_14
        reload_high_reg <= count_high_reg; // see RULE_04, RULE_15
      end else begin
        if (wr_reload_low) begin
          reload_low_reg <= sfr_wdata; // see RULE_14
        end
        if (wr_reload_high) begin
          reload_high_reg <= sfr_wdata; // see RULE_15
        end
      end
    end
  end

  // plain control bits, written by software only
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      low_byte_irq_enable   <= 1'b0;
      capture_enable        <= 1'b0;
      split_enable          <= 1'b0;
      run_control           <= 1'b0;
      capture_source_select <= 1'b0;
      ext_clock_select      <= 1'b0;
    end else if (clk_en && wr_control) begin
      low_byte_irq_enable   <= sfr_wdata[TMR_BIT_LOW_IRQ_EN];
      capture_enable        <= sfr_wdata[TMR_BIT_CAPTURE_EN]; // see RULE_01
      split_enable          <= sfr_wdata[TMR_BIT_SPLIT_EN]; // see RULE_10
      run_control           <= sfr_wdata[TMR_BIT_RUN]; // see RULE_11
      capture_source_select <= sfr_wdata[TMR_BIT_CAP_SRC]; // see RULE_02
      ext_clock_select      <= sfr_wdata[TMR_BIT_EXT_CLK]; // see RULE_12
    end
  end

  // sticky flags; a hardware set wins over a software clear
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      high_overflow_flag <= 1'b0;
      low_overflow_flag  <= 1'b0;
    end else if (clk_en) begin
      if (wrap_high || capture_event) begin
        high_overflow_flag <= 1'b1; // see RULE_04, RULE_06, RULE_17
      end else if (wr_control) begin
        high_overflow_flag <= sfr_wdata[TMR_BIT_HIGH_OVF]; // see RULE_07
      end
      if (wrap_low) begin
        low_overflow_flag <= 1'b1; // see RULE_08
      end else if (wr_control) begin
        low_overflow_flag <= sfr_wdata[TMR_BIT_LOW_OVF];
      end
    end
  end

  // interrupt request follows the flags, registered
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      timer_irq_req <= 1'b0;
    end else if (clk_en) begin
      timer_irq_req <= timer_irq_global_enable &&
                       (high_overflow_flag ||
                        (low_byte_irq_enable && low_overflow_flag)); // see RULE_07, RULE_09
    end
  end

  // one-cycle capture strobe, registered on the same edge as the latch
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      capture_strobe <= 1'b0;
    end else if (clk_en) begin
      capture_strobe <= capture_event; // see RULE_20
    end
  end

  // registered read data; unmapped addresses return zero
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sfr_rdata <= TMR_RESET_BYTE;
    end else if (clk_en && sfr_rd) begin
      case (sfr_addr)
        TMR_ADDR_CONTROL: begin
          sfr_rdata <= {high_overflow_flag, low_overflow_flag,
                        low_byte_irq_enable, capture_enable, split_enable,
                        run_control, capture_source_select, ext_clock_select};
        end
        TMR_ADDR_RELOAD_LOW: begin
          sfr_rdata <= reload_low_reg;
        end
        TMR_ADDR_RELOAD_HIGH: begin
          sfr_rdata <= reload_high_reg;
        end
        TMR_ADDR_COUNT_LOW: begin
          sfr_rdata <= count_low_reg;
        end
        TMR_ADDR_COUNT_HIGH: begin
          sfr_rdata <= count_high_reg;
        end
        default: begin
          sfr_rdata <= TMR_RESET_BYTE;
        end
      endcase
    end
  end

endmodule : tmr_timer

// *** tmr_timer_asserts.sv ***
// concurrent checks on the ports of the capture/auto-reload timer
`timescale 1ns/1ps
module tmr_timer_chk
  import tmr_pkg::*;
(
  // clock, reset, enable
  input wire logic       clk_sys,
  input wire logic       srst,
  input wire logic       clk_en,
  // register bus
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_rdata,
  // clock selects and sources
  input wire logic       high_byte_clock_select,
  input wire logic       low_byte_clock_select,
  input wire logic       ext_clock,
  input wire logic       usb_sof,
  input wire logic       low_frequency_oscillator,
  // interrupt side
  input wire logic       timer_irq_global_enable,
  input wire logic       timer_irq_req,
  input wire logic       capture_strobe
);
  logic [7:0] ctl_reg;
  logic       mapped;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // shadow of the last control write; flags ignored, only mode bits used
  always_ff @(posedge clk_sys) begin
    if (srst) ctl_reg <= 8'h00;
    else if (clk_en && sfr_wr && sfr_addr == TMR_ADDR_CONTROL) ctl_reg <= sfr_wdata;
  end
  // address decode of the five registers
  assign mapped = sfr_addr inside {TMR_ADDR_CONTROL, TMR_ADDR_RELOAD_LOW,
    TMR_ADDR_RELOAD_HIGH, TMR_ADDR_COUNT_LOW, TMR_ADDR_COUNT_HIGH};
  a_reset_zero: assert property ($fell(srst) |-> sfr_rdata == 8'h00 && !timer_irq_req
    && !capture_strobe) else $error("outputs not zero after reset");
  a_unmapped_read: assert property (clk_en && sfr_rd && !mapped |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (clk_en && !sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
  a_ctrl_readback: assert property (sfr_wr && sfr_addr == TMR_ADDR_CONTROL ##1 !sfr_wr
    ##1 sfr_rd && sfr_addr == TMR_ADDR_CONTROL |=> sfr_rdata[5:0] == $past(sfr_wdata[5:0], 3))
    else $error("control bits lost");
  a_reload_readback: assert property (sfr_wr && sfr_addr == TMR_ADDR_RELOAD_LOW
    && !ctl_reg[TMR_BIT_CAPTURE_EN] ##1 !sfr_wr ##1 sfr_rd && sfr_addr == TMR_ADDR_RELOAD_LOW
    |=> sfr_rdata == $past(sfr_wdata, 3)) else $error("reload low lost");
  a_strobe_pulse: assert property (capture_strobe |=> !capture_strobe)
    else $error("capture strobe longer than one cycle");
  a_sof_capture: assert property ($rose(usb_sof) && ctl_reg[TMR_BIT_CAPTURE_EN]
    && !ctl_reg[TMR_BIT_CAP_SRC] |-> ##[1:6] capture_strobe) else $error("frame start missed");
  a_osc_capture: assert property ($fell(low_frequency_oscillator) && ctl_reg[4] && ctl_reg[1]
    |-> ##[1:6] capture_strobe) else $error("oscillator fall missed");
  a_strobe_cause: assert property (capture_strobe |-> $past(ctl_reg[TMR_BIT_CAPTURE_EN]))
    else $error("capture while disabled");
  a_irq_gate: assert property (timer_irq_req |-> $past(timer_irq_global_enable))
    else $error("request without global enable");
  a_irq_clear: assert property (sfr_wr && sfr_addr == TMR_ADDR_CONTROL && sfr_wdata == 8'h00
    ##1 !sfr_wr [*2] |=> !timer_irq_req) else $error("request stays after clear");
  // main scenarios reached
  c_strobe: cover property (capture_strobe);
  c_irq: cover property (timer_irq_req);
  c_unmapped: cover property (sfr_rd && !mapped);
endmodule : tmr_timer_chk
bind tmr_timer tmr_timer_chk u_chk (.*);

// *** tmr_src_model.sv ***
// capture sources and free external oscillator seen by the timer
`timescale 1ns/1ps
module tmr_src_model (
  // clock
  input  wire logic clk_sys,
  // sources
  output logic      usb_sof,
  output logic      low_frequency_oscillator,
  output logic      ext_clock
);
  // oscillator runs free at six system clocks a period; its edges never
  // meet a rising system clock edge, so the tick count over a window is exact
  initial begin
    usb_sof = 1'b0;
    low_frequency_oscillator = 1'b1;
    ext_clock = 1'b0;
    forever #24 ext_clock = ~ext_clock;
  end
  // one event, held three clocks so both sync flops see it
  task automatic pulse(input logic osc);
    @(posedge clk_sys);
    #1;
    if (osc) low_frequency_oscillator = 1'b0;
    else usb_sof = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    usb_sof = 1'b0;
    low_frequency_oscillator = 1'b1;
  endtask : pulse
endmodule : tmr_src_model

// *** test_timer_with_capture_autoreload.sv ***
// self-checking bench of the capture/auto-reload timer
`timescale 1ns/1ps
module test_timer_with_capture_autoreload;
  import tmr_pkg::*;
  logic        clk_sys, srst, clk_en, sfr_wr, sfr_rd, ext_clock, usb_sof, capture_strobe;
  logic        high_byte_clock_select, low_byte_clock_select, low_frequency_oscillator;
  logic        timer_irq_global_enable, timer_irq_req;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata;
  logic [15:0] r, e;
  logic [7:0]  modes [4] = '{8'h04, 8'h08, 8'h0C, 8'h28};
  logic [7:0]  amap [6] = '{8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hC9};
  int          fails, n_compared, n_strobe, k, seed;
  tmr_timer DUT (.clk_sys(clk_sys), .srst(srst), .clk_en(clk_en), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .high_byte_clock_select(high_byte_clock_select),
    .low_byte_clock_select(low_byte_clock_select),
    .ext_clock(ext_clock), .usb_sof(usb_sof), .low_frequency_oscillator(low_frequency_oscillator),
    .timer_irq_global_enable(timer_irq_global_enable), .timer_irq_req(timer_irq_req),
    .capture_strobe(capture_strobe));
  tmr_src_model u_src (.clk_sys(clk_sys), .usb_sof(usb_sof), .ext_clock(ext_clock),
    .low_frequency_oscillator(low_frequency_oscillator));
  // 125 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // count strobes seen by the design
  always @(posedge clk_sys) if (capture_strobe === 1'b1) n_strobe++;
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : idle
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    idle(1);
    sfr_wr = 1'b0;
    idle(1);
  endtask : wr
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // read waits two cycles; data holds until the next read
  task automatic chk(input logic [7:0] a, input logic [7:0] exp);
    sfr_addr = a;
    sfr_rd = 1'b1;
    idle(1);
    sfr_rd = 1'b0;
    idle(1);
    cmp(sfr_rdata, exp);
  endtask : chk
  // count after n ticks from FF:FE; split high byte wraps on its first tick when run is set, else holds FF
  function automatic logic [15:0] exp_cnt(input logic [7:0] c, input logic [15:0] rl, input int n);
    if (!c[3]) return rl + 16'(n - 2);
    return {c[2] ? rl[15:8] + 8'(n - 1) : 8'hFF, rl[7:0] + 8'(n - 2)};
  endfunction : exp_cnt
  task automatic complete_run;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  // whole run is near 1250 clocks; far beyond that means a hang
  initial begin
    #100000;
    fails++;
    complete_run();
  end
  initial begin
    seed = 32'h111938d1;
    {srst, clk_en, high_byte_clock_select, low_byte_clock_select} = 4'hF;
    {sfr_wr, sfr_rd, sfr_addr, sfr_wdata, timer_irq_global_enable} = 19'h00001;
    idle(6);
    srst = 1'b0;
    foreach (amap[i]) chk(amap[i], 8'h00);
    wr(TMR_ADDR_CONTROL, 8'h2B);
    chk(TMR_ADDR_CONTROL, 8'h2B);
    wr(TMR_ADDR_CONTROL, 8'h00);
    // clock enable low freezes the free-running split low byte; it steps twice
    wr(TMR_ADDR_COUNT_LOW, 8'h00);
    wr(TMR_ADDR_CONTROL, 8'h08);
    clk_en = 1'b0;
    idle(20);
    clk_en = 1'b1;
    wr(TMR_ADDR_CONTROL, 8'h00);
    chk(TMR_ADDR_COUNT_LOW, 8'h02);
    r = 16'($random(seed));
    wr(TMR_ADDR_RELOAD_LOW, r[7:0]);
    chk(TMR_ADDR_RELOAD_LOW, r[7:0]);
    // reload runs; small reload values keep to a single wrap per byte
    foreach (modes[i]) begin
      r = 16'($random(seed)) & 16'h7F7F;
      k = 1 + ($random(seed) & 15);
      wr(TMR_ADDR_COUNT_LOW, 8'hFE);
      wr(TMR_ADDR_COUNT_HIGH, 8'hFF);
      wr(TMR_ADDR_RELOAD_LOW, r[7:0]);
      wr(TMR_ADDR_RELOAD_HIGH, r[15:8]);
      wr(TMR_ADDR_CONTROL, modes[i]);
      idle(k);
      chk(TMR_ADDR_CONTROL, modes[i] | (modes[i][2] ? 8'hC0 : 8'h40));
      cmp({7'h00, timer_irq_req}, {7'h00, modes[i][2] | modes[i][5]});
      wr(TMR_ADDR_CONTROL, 8'h00);
      e = exp_cnt(modes[i], r, k + 4);
      chk(TMR_ADDR_COUNT_LOW, e[7:0]);
      chk(TMR_ADDR_COUNT_HIGH, e[15:8]);
    end
    // divide by 12, then external divide by 8, over 480 clocks; 480 is a whole
    // number of both tick periods, so the free prescaler phase cannot matter
    {high_byte_clock_select, low_byte_clock_select} = 2'h0;
    for (int x = 0; x < 2; x++) begin
      wr(TMR_ADDR_COUNT_LOW, 8'h00);
      wr(TMR_ADDR_CONTROL, 8'h04 | 8'(x));
      idle(478);
      wr(TMR_ADDR_CONTROL, 8'h00);
      chk(TMR_ADDR_COUNT_LOW, x ? 8'h0A : 8'h28);
      chk(TMR_ADDR_COUNT_HIGH, 8'hFF);
    end
    // wrong source ignored, right one latches both bytes; the second pass
    // splits, so the low byte runs 18 clocks between control write and latch
    {high_byte_clock_select, low_byte_clock_select} = 2'h3;
    for (int s = 0; s < 2; s++) begin
      r = 16'($random(seed)) & 16'hFF7F;
      timer_irq_global_enable = 1'(s);
      wr(TMR_ADDR_RELOAD_LOW, 8'h00);
      wr(TMR_ADDR_COUNT_LOW, r[7:0]);
      wr(TMR_ADDR_COUNT_HIGH, r[15:8]);
      wr(TMR_ADDR_CONTROL, 8'h10 | 8'(s * 10));
      u_src.pulse(!s);
      idle(8);
      chk(TMR_ADDR_RELOAD_LOW, 8'h00);
      u_src.pulse(1'(s));
      idle(8);
      chk(TMR_ADDR_RELOAD_LOW, r[7:0] + 8'(s * 18));
      chk(TMR_ADDR_RELOAD_HIGH, r[15:8]);
      chk(TMR_ADDR_CONTROL, 8'h90 | 8'(s * 10));
      cmp({7'h00, timer_irq_req}, 8'(s));
      cmp(8'(n_strobe), 8'(s + 1));
    end
    wr(TMR_ADDR_CONTROL, 8'h00);
    u_src.pulse(1'b0);
    idle(8);
    cmp(8'(n_strobe), 8'h02);
    complete_run();
  end
endmodule : test_timer_with_capture_autoreload
